// ===== dpt_regs.vh
// Constants for the drive protection trip logic
`ifndef DPT_REGS_VH
`define DPT_REGS_VH

// =====================================================================
// Stall option field bit positions
`define DPT_STALL_ACC_BIT     0
`define DPT_STALL_STEADY_BIT  1
`define DPT_STALL_DEC_BIT     2
`define DPT_FLUX_BRAKE_BIT    3

// =====================================================================
// Thermal action and source codes
`define DPT_THERM_ACT_NONE    2'h0
`define DPT_THERM_ACT_BLOCK   2'h1
`define DPT_THERM_ACT_DEC     2'h2
`define DPT_THERM_SRC_V       2'h0
`define DPT_THERM_SRC_I       2'h1
`define DPT_THERM_SRC_V_EXT   2'h2
`define DPT_THERM_SRC_I_EXT   2'h3
`define DPT_THERM_AREA_LOW    1'b0

// Full scale of the analog inputs in millivolts
`define DPT_FS_VOLT_MV        14'd10000
`define DPT_FS_CURR_MV        14'd5000
// Threshold level is in tenths of a percent, 1000 is full scale
`define DPT_LEVEL_FULL        11'd1000

// =====================================================================
// Multi-function input assignment codes
`define DPT_FN_EXT_TRIP       7'h04
`define DPT_FN_THERMAL_IN     7'h27

// =====================================================================
// Phase loss check bits and gates
`define DPT_PHASE_OUT_BIT     0
`define DPT_PHASE_IN_BIT      1
`define DPT_IN_PHASE_CURR_PCT 9'd75
`define DPT_RIPPLE_BAND_RST   7'h28

// =====================================================================
// Overload timing: 150 percent for 1 minute, 1 ms ticks
`define DPT_CLK_NS            10
`define DPT_TICK_US           1000
`define DPT_OL_RATED_PCT      9'd100
`define DPT_OL_PCT            50
`define DPT_OL_TIME_MS        60000
`define DPT_OL_WARN_PCT       60

// =====================================================================
// Trip cause bit positions
`define DPT_TRIP_THERMAL      0
`define DPT_TRIP_BIMETAL      1
`define DPT_TRIP_OUT_PHASE    2
`define DPT_TRIP_IN_PHASE     3
`define DPT_TRIP_EXTERNAL     4
`define DPT_TRIP_OVERLOAD     5
`define DPT_TRIP_W            6

`endif

// ===== dpt_overload_acc.v
// Inverse-time overload accumulator with warning and trip levels
`timescale 1ns/10ps
`default_nettype none
`include "dpt_regs.vh"

module dpt_overload_acc
#(
  parameter integer TICK_CYCLES = (`DPT_TICK_US * 1000) / `DPT_CLK_NS,
  parameter integer TRIP_LIMIT  = `DPT_OL_PCT * `DPT_OL_TIME_MS,
  parameter integer WARN_LIMIT  = (TRIP_LIMIT / 100) * `DPT_OL_WARN_PCT
)
(
  input  wire       i_clk,
  input  wire       i_reset_n,
  input  wire [8:0] i_current_pct,
  output reg        o_warn,
  output reg        o_trip
);

  reg  [16:0] tick_cnt_q;
  reg  [23:0] acc_q;
  wire        tick;
  wire        over;
  wire [23:0] excess;

  assign tick   = (tick_cnt_q == TICK_CYCLES[16:0] - 17'h00001);
  assign over   = (i_current_pct > `DPT_OL_RATED_PCT);
  assign excess = {15'h0000, i_current_pct - `DPT_OL_RATED_PCT};

  // =====================================================================
  // Millisecond tick prescaler
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      tick_cnt_q <= 17'h00000;
    else if (tick)
      tick_cnt_q <= 17'h00000;
    else
      tick_cnt_q <= tick_cnt_q + 17'h00001;
  end

  // =====================================================================
  // Excess current over rating charges, rated or less discharges
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      acc_q <= 24'h000000;
    else if (tick)
    begin
      if (over)
        acc_q <= (acc_q + excess >= TRIP_LIMIT[23:0]) ? TRIP_LIMIT[23:0]
                                                      : acc_q + excess;
      else if (acc_q != 24'h000000)
        acc_q <= acc_q - 24'h000001;
    end
  end

  // =====================================================================
  // Registered warning and trip levels
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_warn <= 1'b0;
      o_trip <= 1'b0;
    end
    else
    begin
      o_warn <= (acc_q >= WARN_LIMIT[23:0]);  // [RULE18]
      o_trip <= (acc_q >= TRIP_LIMIT[23:0]);  // [RULE17]
    end
  end

endmodule // dpt_overload_acc

`default_nettype wire

// ===== dpt_protect.v
// Drive protection: stall prevention, flux braking and protective trips
// Overview of operation
// [RULE1] Code 1000 enables flux braking on deceleration
// [RULE2] Code 1100 runs decel stall and flux
// [RULE3] Acceleration stall suspends the ramp
// [RULE4] Four bands, each clamped by its neighbours
// [RULE5] While starting, only band one level counts
// [RULE6] Overheat: action 1 blocks, 2 decelerates
// [RULE7] Sensor source selects one of four inputs
// [RULE8] Threshold is percent of input full scale
// [RULE9] Area 0 trips below, 1 above
// [RULE10] Input function 39 is bimetal overheat trip
// [RULE11] Output phase open trips when enabled
// [RULE12] Input phase open trips when enabled
// [RULE13] Input phase check needs about 75 percent current
// [RULE14] Ripple beyond band means input phase open
// [RULE15] Input function 4 is external trip
// [RULE16] Per-input polarity bit: 0 NO, 1 NC
// [RULE17] Overload trip at 150 percent for one minute
// [RULE18] Overload warning at 60 percent of time
// [RULE19] Stall field bits: acc, steady, dec, flux
// [RULE20] Current above stall level turns accel to decel
// [RULE21] Trips stay latched until fault reset
`timescale 1ns/10ps
`default_nettype none
`include "dpt_regs.vh"

module dpt_protect
#(
  parameter integer N_INPUTS    = 8,
  parameter integer FREQ_W      = 16,
  parameter integer TICK_CYCLES = (`DPT_TICK_US * 1000) / `DPT_CLK_NS
)
(
  input  wire                    i_clk,
  input  wire                    i_reset_n,
  input  wire                    i_fault_reset,
  // Ramp state from the speed controller
  input  wire                    i_accel,
  input  wire                    i_steady,
  input  wire                    i_decel,
  input  wire                    i_starting,
  input  wire                    i_dc_link_high,
  input  wire [FREQ_W-1:0]       i_out_freq,
  input  wire [8:0]              i_out_current_pct,
  // Stall configuration
  input  wire [3:0]              i_stall_option,
  input  wire [FREQ_W-1:0]       i_start_freq,
  input  wire [FREQ_W-1:0]       i_max_freq,
  input  wire [4*FREQ_W-1:0]     i_stall_freq,
  input  wire [4*9-1:0]          i_stall_level,
  // Motor thermal sensor
  input  wire [1:0]              i_thermal_action,
  input  wire [1:0]              i_thermal_src,
  input  wire [10:0]             i_thermal_level,
  input  wire                    i_thermal_area,
  input  wire [13:0]             i_voltage_analog_input,
  input  wire [13:0]             i_current_analog_input,
  input  wire [13:0]             i_ext_voltage_input,
  input  wire [13:0]             i_ext_current_input,
  // Multi-function digital inputs
  input  wire [N_INPUTS-1:0]     i_mf_input,
  input  wire [N_INPUTS-1:0]     i_input_contact_polarity,
  input  wire [7*N_INPUTS-1:0]   i_multifunction_input_assign,
  // Phase loss
  input  wire [1:0]              i_phase_loss_chk,
  input  wire [2:0]              i_out_phase_open,
  input  wire [7:0]              i_dc_ripple_v,
  input  wire [6:0]              i_dc_ripple_band,
  // Outputs
  output wire                    o_ramp_hold,
  output wire                    o_stall_decel,
  output wire                    o_decel_stall_hold,
  output wire                    o_flux_brake,
  output reg  [8:0]              o_stall_level_active,
  output reg                     o_output_block,
  output reg                     o_decel_stop,
  output reg  [`DPT_TRIP_W-1:0]  o_trip_cause,
  output wire                    o_drive_overload_warn_fn
);

  // =====================================================================
  // Input assignment decode, shared by every input function
  function any_input_fn;
    input [7*N_INPUTS-1:0] assign_v;
    input [N_INPUTS-1:0]   active_v;
    input [6:0]            code;
    integer k;
    begin
      any_input_fn = 1'b0;
      for (k = 0; k < N_INPUTS; k = k + 1)
        if (assign_v[7*k +: 7] == code && active_v[k])
          any_input_fn = 1'b1;
    end
  endfunction

  // Clamp a frequency between two limits
  function [FREQ_W-1:0] clamp_freq;
    input [FREQ_W-1:0] v;
    input [FREQ_W-1:0] lo;
    input [FREQ_W-1:0] hi;
    begin
      if (v < lo)
        clamp_freq = lo;
      else if (v > hi)
        clamp_freq = hi;
      else
        clamp_freq = v;
    end
  endfunction

  // =====================================================================
  // Stall bands
  wire [FREQ_W-1:0] band_freq [0:3];
  wire [FREQ_W-1:0] band_lo   [0:3];
  wire [FREQ_W-1:0] band_hi   [0:3];
  reg  [8:0]        level_d;
  reg               band_hit;
  integer           b;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_band
      // Each band's limits come from its neighbours, or from the start and max frequency at the two ends
      if (g == 0)
      begin : g_first
        assign band_lo[g] = i_start_freq;
      end
      else
      begin : g_mid_lo
        assign band_lo[g] = band_freq[g-1];
      end
      if (g == 3)
      begin : g_last
        assign band_hi[g] = i_max_freq;
      end
      else
      begin : g_mid_hi
        assign band_hi[g] = i_stall_freq[FREQ_W*(g+1) +: FREQ_W];
      end
      assign band_freq[g] = clamp_freq(i_stall_freq[FREQ_W*g +: FREQ_W],
                                       band_lo[g], band_hi[g]);  // [RULE4]
    end
  endgenerate

  // Pick the stall level of the band holding the output frequency
  always @*
  begin
    level_d  = i_stall_level[27 +: 9];
    band_hit = 1'b0;
    for (b = 0; b < 4; b = b + 1)
      if (!band_hit && i_out_freq <= band_freq[b])
      begin
        level_d  = i_stall_level[9*b +: 9];  // [RULE4]
        band_hit = 1'b1;
      end
    if (i_starting)
      level_d = i_stall_level[8:0];  // [RULE5]
  end

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_stall_level_active <= 9'h000;
    else
      o_stall_level_active <= level_d;
  end

  // =====================================================================
  // Stall prevention and flux braking actions
  wire over_level;
  wire acc_stall;
  wire steady_stall;

  assign over_level   = (i_out_current_pct > o_stall_level_active);
  assign acc_stall    = i_accel & i_stall_option[`DPT_STALL_ACC_BIT]
                        & over_level;  // [RULE19]
  assign steady_stall = i_steady & i_stall_option[`DPT_STALL_STEADY_BIT]
                        & over_level;  // [RULE19]
  // Over the level: stop accelerating and decelerate until it falls
  assign o_stall_decel = (acc_stall | steady_stall) & ~o_output_block;  // [RULE20]
  // Ramp stays suspended, so real accel time stretches
  assign o_ramp_hold = acc_stall & ~o_output_block;  // [RULE3]
  // Decel stall holds ramp while the DC link is high
  assign o_decel_stall_hold = i_decel & i_stall_option[`DPT_STALL_DEC_BIT]
                              & i_dc_link_high & ~o_output_block;  // [RULE2]
  // Flux braking on deceleration, alone or with decel stall
  assign o_flux_brake = i_decel & i_stall_option[`DPT_FLUX_BRAKE_BIT]
                        & ~o_output_block;  // [RULE1] [RULE2]

  // =====================================================================
  // Motor thermal sensor
  reg  [13:0] sensor_mv;
  reg  [13:0] full_mv;
  wire [24:0] sensor_scaled;
  wire [24:0] thresh_scaled;
  wire        therm_hot;

  // Source select and its full scale
  always @*
  begin
    case (i_thermal_src)
      `DPT_THERM_SRC_V:
      begin
        sensor_mv = i_voltage_analog_input;
        full_mv   = `DPT_FS_VOLT_MV;
      end
      `DPT_THERM_SRC_I:
      begin
        sensor_mv = i_current_analog_input;
        full_mv   = `DPT_FS_CURR_MV;
      end
      `DPT_THERM_SRC_V_EXT:
      begin
        sensor_mv = i_ext_voltage_input;
        full_mv   = `DPT_FS_VOLT_MV;
      end
      default:
      begin
        sensor_mv = i_ext_current_input;
        full_mv   = `DPT_FS_CURR_MV;
      end
    endcase  // [RULE7]
  end

  // Compare without division: sensor*1000 against full*level
  assign sensor_scaled = {11'h000, sensor_mv} * {14'h0000, `DPT_LEVEL_FULL};  // [RULE8]
  assign thresh_scaled = {11'h000, full_mv} * {14'h0000, i_thermal_level};  // [RULE8]
  assign therm_hot = (i_thermal_area == `DPT_THERM_AREA_LOW)
                     ? (sensor_scaled < thresh_scaled)
                     : (sensor_scaled > thresh_scaled);  // [RULE9]

  // =====================================================================
  // Multi-function inputs with per-input contact polarity
  wire [N_INPUTS-1:0] input_active;
  wire                bimetal_hot;
  wire                ext_trip;

  // NO contact active when closed, NC contact active when open
  assign input_active = i_mf_input ^ i_input_contact_polarity;  // [RULE16]
  assign bimetal_hot  = any_input_fn(i_multifunction_input_assign, input_active,
                                     `DPT_FN_THERMAL_IN);  // [RULE10]
  assign ext_trip     = any_input_fn(i_multifunction_input_assign, input_active,
                                     `DPT_FN_EXT_TRIP);  // [RULE15]

  // =====================================================================
  // Phase loss detection
  wire out_phase_fault;
  wire in_phase_fault;
  wire in_phase_gate;

  assign out_phase_fault = i_phase_loss_chk[`DPT_PHASE_OUT_BIT]
                           & (|i_out_phase_open);  // [RULE11]
  assign in_phase_gate   = (i_out_current_pct >= `DPT_IN_PHASE_CURR_PCT);  // [RULE13]
  assign in_phase_fault  = i_phase_loss_chk[`DPT_PHASE_IN_BIT] & in_phase_gate
                           & (i_dc_ripple_v > {1'b0, i_dc_ripple_band});  // [RULE12] [RULE14]

  // =====================================================================
  // Drive overload accumulator
  wire ol_warn;
  wire ol_trip;

  dpt_overload_acc
  #(
    .TICK_CYCLES (TICK_CYCLES)
  )
  u_overload
  (
    .i_clk         (i_clk),
    .i_reset_n     (i_reset_n),
    .i_current_pct (i_out_current_pct),
    .o_warn        (ol_warn),
    .o_trip        (ol_trip)
  );

  assign o_drive_overload_warn_fn = ol_warn;  // [RULE18]

  // =====================================================================
  // Trip latch; a new event wins over the fault reset
  wire [`DPT_TRIP_W-1:0] trip_event;
  wire                   therm_en;

  assign therm_en = (i_thermal_action != `DPT_THERM_ACT_NONE);
  assign trip_event[`DPT_TRIP_THERMAL]   = therm_en & therm_hot;  // [RULE6]
  assign trip_event[`DPT_TRIP_BIMETAL]   = therm_en & bimetal_hot;  // [RULE10]
  assign trip_event[`DPT_TRIP_OUT_PHASE] = out_phase_fault;  // [RULE11]
  assign trip_event[`DPT_TRIP_IN_PHASE]  = in_phase_fault;  // [RULE12]
  assign trip_event[`DPT_TRIP_EXTERNAL]  = ext_trip;  // [RULE15]
  assign trip_event[`DPT_TRIP_OVERLOAD]  = ol_trip;  // [RULE17]

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_trip_cause <= {`DPT_TRIP_W{1'b0}};
    else if (i_fault_reset)
      o_trip_cause <= trip_event;  // [RULE21]
    else
      o_trip_cause <= o_trip_cause | trip_event;  // [RULE21]
  end

  // =====================================================================
  // Stop action: thermal Dec code decelerates, all else blocks
  wire thermal_dec;
  wire any_block;

  assign thermal_dec = (i_thermal_action == `DPT_THERM_ACT_DEC);
  assign any_block   = |(trip_event & ~{`DPT_TRIP_W{1'b0}} &
                         {1'b1, 1'b1, 1'b1, 1'b1, ~thermal_dec, ~thermal_dec});

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_output_block <= 1'b0;
      o_decel_stop   <= 1'b0;
    end
    else if (any_block)
    begin
      o_output_block <= 1'b1;  // [RULE6] [RULE11] [RULE12] [RULE15]
      o_decel_stop   <= 1'b0;
    end
    else if (trip_event[`DPT_TRIP_THERMAL] | trip_event[`DPT_TRIP_BIMETAL])
      o_decel_stop <= ~o_output_block;  // [RULE6]
    else if (i_fault_reset)
    begin
      o_output_block <= 1'b0;  // [RULE21]
      o_decel_stop   <= 1'b0;
    end
  end

endmodule // dpt_protect

`default_nettype wire

// ===== dpt_protect_monitor.sv
// Assertion checker for the drive protection trip logic
`timescale 1ns/10ps
`default_nettype none
module dpt_protect_monitor
#(
  parameter int N_INPUTS = 8
)
(
  input wire logic                  i_clk,
  input wire logic                  i_reset_n,
  input wire logic                  i_fault_reset,
  input wire logic                  i_accel,
  input wire logic                  i_decel,
  input wire logic                  i_starting,
  input wire logic [8:0]            i_out_current_pct,
  input wire logic [3:0]            i_stall_option,
  input wire logic [35:0]           i_stall_level,
  input wire logic [1:0]            i_thermal_action,
  input wire logic [N_INPUTS-1:0]   i_mf_input,
  input wire logic [N_INPUTS-1:0]   i_input_contact_polarity,
  input wire logic [7*N_INPUTS-1:0] i_multifunction_input_assign,
  input wire logic [1:0]            i_phase_loss_chk,
  input wire logic [2:0]            i_out_phase_open,
  input wire logic [7:0]            i_dc_ripple_v,
  input wire logic [6:0]            i_dc_ripple_band,
  input wire logic                  o_ramp_hold,
  input wire logic                  o_flux_brake,
  input wire logic [8:0]            o_stall_level_active,
  input wire logic                  o_output_block,
  input wire logic [5:0]            o_trip_cause,
  input wire logic                  o_drive_overload_warn_fn
);
  logic ext_hit;
  logic bimetal_hit;
  logic run_q;

  // ==================================================================
  // Decode the active contacts per assigned function
  always_comb
  begin
    ext_hit = 1'b0;
    bimetal_hit = 1'b0;
    for (int k = 0; k < N_INPUTS; k++)
    begin
      if (i_multifunction_input_assign[7*k +: 7] == 7'h04)
        ext_hit = ext_hit | (i_mf_input[k] ^ i_input_contact_polarity[k]);
      if (i_multifunction_input_assign[7*k +: 7] == 7'h27)
        bimetal_hit = bimetal_hit | (i_mf_input[k] ^ i_input_contact_polarity[k]);
    end
  end

  // Goes high one edge after reset so past values are live
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      run_q <= 1'b0;
    else
      run_q <= 1'b1;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence start_seen;
    run_q && i_starting;
  endsequence

  // ==================================================================
  // Properties
  ext_trip_a: assert property (ext_hit |=> o_trip_cause[4] && o_output_block)
    else $error("external trip not latched");
  bimetal_trip_a: assert property (bimetal_hit && i_thermal_action != 2'h0 |=> o_trip_cause[1])
    else $error("bimetal trip not latched");
  out_phase_a: assert property (i_phase_loss_chk[0] && |i_out_phase_open
    |=> o_trip_cause[2] && o_output_block)
    else $error("output phase open not tripped");
  in_phase_a: assert property (i_phase_loss_chk[1] && i_out_current_pct >= 9'd75 &&
    i_dc_ripple_v > {1'b0, i_dc_ripple_band} |=> o_trip_cause[3])
    else $error("input phase open not tripped");
  in_gate_a: assert property (!(i_phase_loss_chk[1] && i_out_current_pct >= 9'd75)
    |=> !$rose(o_trip_cause[3]))
    else $error("input phase trip at low current");
  trip_hold_a: assert property ((|($past(o_trip_cause) & ~o_trip_cause) || $fell(o_output_block))
    |-> $past(i_fault_reset))
    else $error("trip released without fault reset");
  flux_brake_a: assert property (o_flux_brake == (i_decel && i_stall_option[3] && !o_output_block))
    else $error("flux braking mismatch");
  ramp_hold_a: assert property (i_accel && i_stall_option[0] && !o_output_block &&
    i_out_current_pct > o_stall_level_active |-> o_ramp_hold)
    else $error("ramp not held on stall");
  ramp_cause_a: assert property (o_ramp_hold |-> i_accel && i_stall_option[0])
    else $error("ramp held without acceleration stall");
  start_level_a: assert property (start_seen |=> o_stall_level_active == $past(i_stall_level[8:0]))
    else $error("starting level is not band one");
  warn_first_a: assert property ($rose(o_trip_cause[5]) |-> o_drive_overload_warn_fn)
    else $error("overload trip without warning");
endmodule // dpt_protect_monitor

bind dpt_protect dpt_protect_monitor #(.N_INPUTS(N_INPUTS)) i_monitor (.*);
`default_nettype wire

// ===== dpt_field_model.sv
// Field side model: external trip contacts and their wiring
`timescale 1ns/10ps
`default_nettype none
module dpt_field_model
(
  input  wire logic [7:0] i_contact_fault,
  input  wire logic [7:0] i_contact_nc,
  output logic      [7:0] o_contact
);
  // A normally open contact closes on a fault, a normally closed one opens
  assign o_contact = i_contact_fault ^ i_contact_nc;
endmodule // dpt_field_model
`default_nettype wire

// ===== dpt_protect_tb.sv
// Self-checking testbench for the drive protection trip logic
`timescale 1ns/10ps
`default_nettype none
module dpt_protect_tb;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_fault_reset = 1'b0;
  logic        i_accel, i_steady, i_decel, i_starting, i_dc_link_high, i_thermal_area;
  logic [15:0] i_out_freq, i_start_freq, i_max_freq;
  logic [8:0]  i_out_current_pct, o_stall_level_active;
  logic [3:0]  i_stall_option;
  logic [63:0] i_stall_freq;
  logic [35:0] i_stall_level;
  logic [1:0]  i_thermal_action, i_thermal_src, i_phase_loss_chk;
  logic [10:0] i_thermal_level;
  logic [13:0] i_voltage_analog_input, i_current_analog_input;
  logic [13:0] i_ext_voltage_input, i_ext_current_input;
  logic [7:0]  i_mf_input, i_input_contact_polarity, fault, i_dc_ripple_v;
  logic [55:0] i_multifunction_input_assign;
  logic [2:0]  i_out_phase_open;
  logic [6:0]  i_dc_ripple_band;
  logic        o_ramp_hold, o_stall_decel, o_decel_stall_hold, o_flux_brake;
  logic        o_output_block, o_decel_stop, o_drive_overload_warn_fn;
  logic [5:0]  o_trip_cause;
  logic [3:0]  opts [3] = '{4'h8, 4'hc, 4'h4};
  logic [8:0]  lv [3] = '{9'd102, 9'd101, 9'd104};
  int          fq [3] = '{150, 50, 450};
  int          n_fail = 0;
  int          n_tests = 0;
  int          thr;

  // ==================================================================
  // Design, field model and clock
  dpt_protect #(.TICK_CYCLES(10)) i_dut (.*);
  dpt_field_model i_field (.i_contact_fault(fault), .i_contact_nc(i_input_contact_polarity),
                           .o_contact(i_mf_input));
  always #5 i_clk = ~i_clk;

  // ==================================================================
  // Tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Benign values for every condition input
  task automatic defaults();
    i_accel = 1'b0;
    i_steady = 1'b0;
    i_decel = 1'b0;
    i_starting = 1'b0;
    i_dc_link_high = 1'b0;
    i_out_current_pct = 9'd50;
    i_stall_option = 4'h0;
    i_thermal_action = 2'h0;
    i_thermal_area = 1'b0;
    i_voltage_analog_input = 14'd9000;
    i_current_analog_input = 14'd9000;
    i_ext_voltage_input = 14'd9000;
    i_ext_current_input = 14'd9000;
    fault = 8'h00;
    i_phase_loss_chk = 2'h0;
    i_out_phase_open = 3'h0;
    i_dc_ripple_v = 8'd0;
  endtask

  // Selected sensor input gets mv, the others read zero
  task automatic sense(input int s, input int mv);
    i_voltage_analog_input = (s == 0) ? 14'(mv) : 14'd0;
    i_current_analog_input = (s == 1) ? 14'(mv) : 14'd0;
    i_ext_voltage_input = (s == 2) ? 14'(mv) : 14'd0;
    i_ext_current_input = (s == 3) ? 14'(mv) : 14'd0;
  endtask

  // Trip seen, held after the cause goes, then cleared by fault reset
  task automatic trip_check(input int idx, input logic blk);
    step(2);
    check("trip cause", o_trip_cause, 6'h01 << idx);
    check("output block", o_output_block, blk);
    defaults();
    step(3);
    check("latched cause", o_trip_cause, 6'h01 << idx);
    i_fault_reset = 1'b1;
    step(1);
    i_fault_reset = 1'b0;
    step(2);
    check("cleared cause", o_trip_cause, 6'h00);
    check("cleared block", o_output_block, 1'b0);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog sized well above the overload run
  initial
  begin
    #900000;
    n_fail++;
    end_of_test();
  end

  // ==================================================================
  // Main sequence
  initial
  begin
    defaults();
    i_out_freq = 16'd150;
    i_start_freq = 16'd10;
    i_max_freq = 16'd1000;
    i_stall_freq = {16'd400, 16'd500, 16'd200, 16'd100};
    i_stall_level = {9'd104, 9'd103, 9'd102, 9'd101};
    i_thermal_src = 2'h0;
    i_thermal_level = 11'd500;
    i_input_contact_polarity = 8'h00;
    i_multifunction_input_assign = 56'h0;
    i_dc_ripple_band = 7'd40;
    repeat (8) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    step(1);
    check("reset cause", o_trip_cause, 6'h00);
    // Band choice, third band clamped down to the fourth
    for (int j = 0; j < 3; j++)
    begin
      i_out_freq = 16'(fq[j]);
      step(2);
      check("band level", o_stall_level_active, lv[j]);
    end
    i_starting = 1'b1;
    step(2);
    check("start level", o_stall_level_active, 9'd101);
    i_starting = 1'b0;
    i_out_freq = 16'd150;
    i_accel = 1'b1;
    i_stall_option = 4'h1;
    i_out_current_pct = 9'd103;
    step(2);
    check("ramp hold", o_ramp_hold, 1'b1);
    check("accel stall", o_stall_decel, 1'b1);
    i_out_current_pct = 9'd102;
    step(1);
    check("ramp resume", o_ramp_hold, 1'b0);
    i_accel = 1'b0;
    i_steady = 1'b1;
    i_stall_option = 4'h2;
    i_out_current_pct = 9'd103;
    step(1);
    check("steady stall", o_stall_decel, 1'b1);
    defaults();
    i_decel = 1'b1;
    i_dc_link_high = 1'b1;
    foreach (opts[j])
    begin
      i_stall_option = opts[j];
      step(1);
      check("flux brake", o_flux_brake, opts[j][3]);
      check("decel stall", o_decel_stall_hold, opts[j][2]);
    end
    defaults();
    // External trip on every input, both contact kinds
    for (int k = 0; k < 8; k++)
    begin
      i_multifunction_input_assign = 56'h0;
      i_multifunction_input_assign[7*k +: 7] = 7'h04;
      i_input_contact_polarity = 8'(k % 2) << k;
      step(2);
      check("idle contact", o_trip_cause, 6'h00);
      fault[k] = 1'b1;
      trip_check(4, 1'b1);
    end
    i_multifunction_input_assign = 56'h0;
    i_multifunction_input_assign[20:14] = 7'h27;
    i_input_contact_polarity = 8'h04;
    i_thermal_action = 2'h1;
    step(2);
    check("bimetal idle", o_trip_cause, 6'h00);
    fault[2] = 1'b1;
    trip_check(1, 1'b1);
    i_multifunction_input_assign = 56'h0;
    i_input_contact_polarity = 8'h00;
    // Thermal sensor on each source, trip below the level
    for (int s = 0; s < 4; s++)
    begin
      thr = (s % 2) ? 2500 : 5000;
      i_thermal_action = 2'h1;
      i_thermal_src = 2'(s);
      sense(s, thr + 100);
      step(2);
      check("above threshold", o_trip_cause, 6'h00);
      sense(s, thr - 100);
      trip_check(0, 1'b1);
    end
    i_thermal_action = 2'h2;
    i_thermal_area = 1'b1;
    sense(3, 2400);
    step(2);
    check("below high area", o_trip_cause, 6'h00);
    sense(3, 2600);
    step(2);
    check("decel stop", o_decel_stop, 1'b1);
    trip_check(0, 1'b0);
    // Phase loss, disabled then each output phase
    i_out_phase_open = 3'h7;
    step(2);
    check("phase check off", o_trip_cause, 6'h00);
    for (int p = 0; p < 3; p++)
    begin
      i_phase_loss_chk = 2'h1;
      i_out_phase_open = 3'h1 << p;
      trip_check(2, 1'b1);
    end
    i_phase_loss_chk = 2'h2;
    i_out_current_pct = 9'd80;
    i_dc_ripple_v = 8'd40;
    step(2);
    check("ripple in band", o_trip_cause, 6'h00);
    i_dc_ripple_v = 8'd41;
    i_out_current_pct = 9'd74;
    step(2);
    check("low current", o_trip_cause, 6'h00);
    i_out_current_pct = 9'd75;
    trip_check(3, 1'b1);
    // Overload at 511 percent: warn near 4380 ticks, trip near 7300
    i_out_current_pct = 9'd511;
    step(43000);
    check("early warn", o_drive_overload_warn_fn, 1'b0);
    step(1500);
    check("overload warn", o_drive_overload_warn_fn, 1'b1);
    step(27500);
    check("early trip", o_trip_cause, 6'h00);
    step(2000);
    check("overload trip", o_trip_cause, 6'h20);
    check("overload block", o_output_block, 1'b1);
    end_of_test();
  end
endmodule // dpt_protect_tb
`default_nettype wire
